// ---- rtl/cvc_regs.svh ----
`ifndef CVC_REGS_SVH
`define CVC_REGS_SVH

// Clock and serial timing
`define CVC_CLK_KHZ      200000
`define CVC_BAUD         9600
`define CVC_BIT_CYC      (`CVC_CLK_KHZ * 1000 / `CVC_BAUD)
`define CVC_MS_TO_CYC(ms) (64'(ms) * 64'(`CVC_CLK_KHZ))

// Session and power-up display times in milliseconds
`define CVC_TIMEOUT_MS   12000
`define CVC_LAMP_MS      1000
`define CVC_VER_MS       1000

// Settings word layout
`define CVC_SET_W        49
`define CVC_FREQ_W       28
`define CVC_GAIN_W       6
`define CVC_ADDR_W       8
`define CVC_F_FREQ       0
`define CVC_F_GAIN       28
`define CVC_F_REFINS     34
`define CVC_F_EXTREF     35
`define CVC_F_REMOTE     36
`define CVC_F_STEP       37
`define CVC_F_LINE       39
`define CVC_F_ADDR       41
`define CVC_FREQ_DIGITS  7

// Reset value: 2050.000 MHz, gain 0, all flags off
`define CVC_RST_SET      49'h0_0000_0205_0000
`define CVC_GAIN_MAX     6'h32

// Frame characters
`define CVC_CH_OPEN      8'h7b
`define CVC_CH_CLOSE     8'h7d
`define CVC_CH_STAT      8'h53
`define CVC_CH_CMD       8'h43
`define CVC_CH_ONE       8'h31
`define CVC_CH_ZERO      8'h30
`define CVC_CH_ACK       8'h3e
`define CVC_ASCII_DIG    4'h3
`define CVC_RX_DEPTH     12

`endif

// ---- rtl/cvc_pkg.sv ----
package cvc_pkg;
  typedef enum logic [12:0] {
    ST_LAMP   = 13'h0001,
    ST_VER    = 13'h0002,
    ST_IDLE   = 13'h0004,
    ST_FREQ   = 13'h0008,
    ST_GAIN   = 13'h0010,
    ST_OTHER  = 13'h0020,
    ST_REMOTE = 13'h0040,
    ST_STEP   = 13'h0080,
    ST_EXTREF = 13'h0100,
    ST_REFOUT = 13'h0200,
    ST_LINE   = 13'h0400,
    ST_ADDR   = 13'h0800,
    ST_SAVE   = 13'h1000
  } cvc_state_t;

  typedef enum logic [1:0] {
    LINE_232 = 2'h0,
    LINE_422 = 2'h1,
    LINE_485 = 2'h2
  } cvc_line_t;

  typedef enum logic [1:0] {
    STEP_1K   = 2'h0,
    STEP_10K  = 2'h1,
    STEP_100K = 2'h2,
    STEP_125K = 2'h3
  } cvc_step_t;
endpackage

// ---- rtl/cvc_uart_rx.sv ----
`timescale 1ns/1ps
`include "cvc_regs.svh"
module cvc_uart_rx #(
  parameter int BIT_CYC = `CVC_BIT_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       rx_line,
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  logic        busy;
  logic [15:0] baud;
  logic [3:0]  nbit;
  logic [7:0]  shreg;

  // Start bit is checked at half a bit, data at full bit spacing
  wire [15:0] bit_lim = (nbit == 4'h0) ? 16'(BIT_CYC / 2 - 1) : 16'(BIT_CYC - 1);
  wire        bit_end = (baud == bit_lim);

  // Frame: start, eight data bits LSB first, one stop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy     <= 1'b0;
      baud     <= 16'h0000;
      nbit     <= 4'h0;
      shreg    <= 8'h00;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (!busy) begin
        baud <= 16'h0000;
        nbit <= 4'h0;
        busy <= ~rx_line;
      end else if (!bit_end) begin
        baud <= baud + 16'h0001;
      end else begin
        baud <= 16'h0000;
        if (nbit == 4'h0) begin
          busy <= ~rx_line;        // Glitch, not a start bit
          nbit <= 4'h1;
        end else if (nbit <= 4'h8) begin
          shreg <= {rx_line, shreg[7:1]};
          nbit  <= nbit + 4'h1;
        end else begin
          busy <= 1'b0;
          if (rx_line) begin       // Bad stop bit drops the character
            rx_valid <= 1'b1;
            rx_data  <= shreg;
          end
        end
      end
    end
  end
endmodule

// ---- rtl/cvc_uart_tx.sv ----
`timescale 1ns/1ps
`include "cvc_regs.svh"
module cvc_uart_tx #(
  parameter int BIT_CYC = `CVC_BIT_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic            tx_line
);
  logic        busy;
  logic [15:0] baud;
  logic [3:0]  nbit;
  logic [8:0]  shreg;

  assign tx_ready = ~busy;
  wire bit_end = (baud == 16'(BIT_CYC - 1));

  // Ten bit periods per character; stop bit rides in the shift register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy    <= 1'b0;
      baud    <= 16'h0000;
      nbit    <= 4'h0;
      shreg   <= 9'h1ff;
      tx_line <= 1'b1;
    end else if (!busy) begin
      if (tx_valid) begin
        busy    <= 1'b1;
        baud    <= 16'h0000;
        nbit    <= 4'h0;
        shreg   <= {1'b1, tx_data};
        tx_line <= 1'b0;
      end
    end else if (!bit_end) begin
      baud <= baud + 16'h0001;
    end else begin
      baud <= 16'h0000;
      if (nbit == 4'h9) begin
        busy <= 1'b0;
      end else begin
        tx_line <= shreg[0];
        shreg   <= {1'b1, shreg[8:1]};
        nbit    <= nbit + 4'h1;
      end
    end
  end
endmodule

// ---- rtl/cvc_ctrl.sv ----
// Contract
// - Query {S1} answered by brace echo, seven freq, two gain, three flags.
// - Insertion flag is one when reference insertion on, zero when off.
// - External reference flag is one when external off, zero when on.
// - Alarm flag is zero without alarm, one with alarm.
// - Serial framing 9600 baud, start, eight data, no parity, one stop.
// - Session starts and ends with menu press; unconfirmed changes other than gain never apply.
// - About 12 s without switch activity abandons session, restores settings.
// - Saved settings live in non-volatile storage and reload at power-up.
// - Power-up shows all segments, then version, then frequency and gain.
// - Edited frequency applies only after save is confirmed.
// - Carrier muted while frequency is being edited.
// - Gain applies immediately, stored only on confirmed save.
// - Save yes stores, no restores; the press returns to default display.
// - Refuse gain outside the output level window limits.
// - Alarm follows loss of PLL lock.
// - Remote mode lights indicator; local controls keep working.
// - Frequency, gain, other first; further items only when other is yes.
// - Step size choices 1, 10, 100 and 125 kHz.
// - Horizontal moves cursor; vertical steps digits or toggles flags.
// - Gain changes by 10 dB or 1 dB by cursor digit.
// - Frames: brace, optional address, letter, digit, data, closing brace.
// - Executed command acknowledged with a greater-than character.
`timescale 1ns/1ps
`include "cvc_regs.svh"
module cvc_ctrl #(
  parameter int          BIT_CYC     = `CVC_BIT_CYC,
  parameter logic [31:0] TIMEOUT_CYC = 32'(`CVC_MS_TO_CYC(`CVC_TIMEOUT_MS)),
  parameter logic [31:0] LAMP_CYC    = 32'(`CVC_MS_TO_CYC(`CVC_LAMP_MS)),
  parameter logic [31:0] VER_CYC     = 32'(`CVC_MS_TO_CYC(`CVC_VER_MS)),
  parameter logic [15:0] FW_VERSION  = 16'h0000  // Arbitrary value
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic                    rx_pin,
  output logic                         tx_pin,
  input  wire logic                    sw_menu,
  input  wire logic                    sw_left,
  input  wire logic                    sw_right,
  input  wire logic                    sw_up,
  input  wire logic                    sw_down,
  input  wire logic                    pll_unlock,
  input  wire logic [`CVC_GAIN_W-1:0]  gain_lo_lim,
  input  wire logic [`CVC_GAIN_W-1:0]  gain_hi_lim,
  input  wire logic [`CVC_SET_W-1:0]   nv_rd_data,
  output logic [`CVC_SET_W-1:0]        nv_wr_data,
  output logic                         nv_wr_en,
  output logic [`CVC_FREQ_W-1:0]       freq_bcd,
  output logic [`CVC_GAIN_W-1:0]       gain_db,
  output logic                         rf_mute,
  output logic                         ref_insert,
  output logic                         ext_ref_sel,
  output cvc_pkg::cvc_step_t           step_sel,
  output cvc_pkg::cvc_line_t           line_std,
  output logic                         alarm_led,
  output logic                         remote_led,
  output cvc_pkg::cvc_state_t          disp_state,
  output logic [3:0]                   disp_cursor,
  output logic [`CVC_SET_W-1:0]        disp_settings,
  output logic                         disp_other,
  output logic                         disp_save_yes,
  output logic [15:0]                  disp_version
);
  import cvc_pkg::*;

  localparam int        NP      = 7;
  localparam [NP-1:0]   PIN_RST = 7'h01;  // Serial line idles high
  localparam int        FD      = `CVC_FREQ_DIGITS;

  function automatic [3:0] bcd_step(input [3:0] d, input up);
    bcd_step = up ? ((d == 4'h9) ? 4'h0 : d + 4'h1) : ((d == 4'h0) ? 4'h9 : d - 4'h1);
  endfunction

  function automatic [3:0] field_len(input cvc_state_t s);
    case (s)
      ST_FREQ:         field_len = 4'(FD);
      ST_GAIN, ST_ADDR: field_len = 4'h2;
      default:         field_len = 4'h1;
    endcase
  endfunction

  function automatic cvc_state_t succ(input cvc_state_t s, input oth);
    case (s)
      ST_FREQ:   succ = ST_GAIN;
      ST_GAIN:   succ = ST_OTHER;
      ST_OTHER:  succ = oth ? ST_REMOTE : ST_SAVE;
      ST_REMOTE: succ = ST_STEP;
      ST_STEP:   succ = ST_EXTREF;
      ST_EXTREF: succ = ST_REFOUT;
      ST_REFOUT: succ = ST_LINE;
      ST_LINE:   succ = ST_ADDR;
      default:   succ = ST_SAVE;
    endcase
  endfunction

  // Pin synchronisers: a level counts once the second and third stages agree
  logic [NP-1:0] s1, s2, s3, pin_f, pin_q;
  wire  [NP-1:0] pin_raw    = {pll_unlock, sw_down, sw_up, sw_right, sw_left, sw_menu, rx_pin};
  wire  [NP-1:0] next_pin_f = ((s2 ~^ s3) & s2) | ((s2 ^ s3) & pin_f);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1    <= PIN_RST;
      s2    <= PIN_RST;
      s3    <= PIN_RST;
      pin_f <= PIN_RST;
      pin_q <= PIN_RST;
    end else begin
      s1    <= pin_raw;
      s2    <= s1;
      s3    <= s2;
      pin_f <= next_pin_f;
      pin_q <= pin_f;
    end
  end

  // Switch press events, one cycle each
  wire [NP-1:0] press   = pin_f & ~pin_q;
  wire          ev_menu = press[1];
  wire          ev_left = press[2];
  wire          ev_rght = press[3];
  wire          ev_up   = press[4];
  wire          ev_down = press[5];
  wire          any_ev  = |press[5:1];
  wire          vert    = ev_up | ev_down;
  wire          alarm   = pin_f[6];

  // Menu state, pending and saved settings
  cvc_state_t            state, next_state;
  logic [3:0]            cur, next_cur;
  logic                  other_sel, next_other;
  logic                  save_yes, next_yes;
  logic [`CVC_SET_W-1:0] pend, next_pend, saved;
  logic                  nv_loaded;
  logic [31:0]           tmr;

  wire [`CVC_FREQ_W-1:0] p_freq = pend[`CVC_F_FREQ +: `CVC_FREQ_W];
  wire [`CVC_GAIN_W-1:0] p_gain = pend[`CVC_F_GAIN +: `CVC_GAIN_W];
  wire [1:0]             p_step = pend[`CVC_F_STEP +: 2];
  wire [1:0]             p_line = pend[`CVC_F_LINE +: 2];
  wire [`CVC_ADDR_W-1:0] p_addr = pend[`CVC_F_ADDR +: `CVC_ADDR_W];
  wire                   in_sess = ~(state == ST_LAMP || state == ST_VER || state == ST_IDLE);

  // Cursor position equal to the field length selects the return mark
  wire [3:0] flen = field_len(state);
  wire       at_r = (cur == flen);
  wire       edit = vert & ~at_r;

  // Frequency digit edit, cursor 0 is the most significant digit
  logic [`CVC_FREQ_W-1:0] freq_ed;
  for (genvar j = 0; j < FD; j++) begin : g_fdig
    wire [3:0] d = p_freq[(FD-1-j)*4 +: 4];
    assign freq_ed[(FD-1-j)*4 +: 4] = (cur == 4'(j)) ? bcd_step(d, ev_up) : d;
  end

  // Address edit, two decimal digits
  wire [`CVC_ADDR_W-1:0] addr_ed = (cur == 4'h0) ?
                                   {bcd_step(p_addr[7:4], ev_up), p_addr[3:0]} :
                                   {p_addr[7:4], bcd_step(p_addr[3:0], ev_up)};

  // Gain edit with range check; a refused step leaves the gain unchanged
  wire [6:0] gstep   = (cur == 4'h0) ? 7'h0a : 7'h01;
  wire [6:0] gcand   = ev_up ? {1'b0, p_gain} + gstep : {1'b0, p_gain} - gstep;
  wire       gain_ok = ~gcand[6] && gcand[5:0] <= `CVC_GAIN_MAX &&
                       gcand[5:0] >= gain_lo_lim && gcand[5:0] <= gain_hi_lim;
  wire [1:0] step_ed = ev_up ? p_step + 2'h1 : p_step - 2'h1;
  wire [1:0] line_ed = ev_up ? ((p_line == 2'h2) ? 2'h0 : p_line + 2'h1) :
                               ((p_line == 2'h0) ? 2'h2 : p_line - 2'h1);

  // Timer: display phases at power-up, inactivity in a session
  wire [31:0] tlim  = (state == ST_LAMP) ? LAMP_CYC : (state == ST_VER) ? VER_CYC : TIMEOUT_CYC;
  wire        tdone = (tmr >= tlim);
  wire        commit = (state == ST_SAVE) && ev_menu && save_yes;

  // Next menu state and pending edits
  always_comb begin
    next_state = state;
    next_cur   = cur;
    next_other = other_sel;
    next_yes   = save_yes;
    next_pend  = pend;
    if (in_sess && ev_left && cur != 4'h0) next_cur = cur - 4'h1;
    if (in_sess && ev_rght && !at_r) next_cur = cur + 4'h1;
    case (state)
      ST_LAMP: if (tdone) next_state = ST_VER;
      ST_VER:  if (tdone) next_state = ST_IDLE;
      ST_IDLE: begin
        if (ev_menu) begin
          next_state = ST_FREQ;
          next_cur   = 4'h0;
          next_other = 1'b0;
        end
      end
      ST_FREQ:   if (edit) next_pend[`CVC_F_FREQ +: `CVC_FREQ_W] = freq_ed;
      ST_GAIN:   if (edit && gain_ok) next_pend[`CVC_F_GAIN +: `CVC_GAIN_W] = gcand[5:0];
      ST_OTHER:  if (edit) next_other = ~other_sel;
      ST_REMOTE: if (edit) next_pend[`CVC_F_REMOTE] = ~pend[`CVC_F_REMOTE];
      ST_EXTREF: if (edit) next_pend[`CVC_F_EXTREF] = ~pend[`CVC_F_EXTREF];
      ST_REFOUT: if (edit) next_pend[`CVC_F_REFINS] = ~pend[`CVC_F_REFINS];
      ST_STEP:   if (edit) next_pend[`CVC_F_STEP +: 2] = step_ed;
      ST_LINE:   if (edit) next_pend[`CVC_F_LINE +: 2] = line_ed;
      ST_ADDR:   if (edit) next_pend[`CVC_F_ADDR +: `CVC_ADDR_W] = addr_ed;
      ST_SAVE:   if (vert) next_yes = ~save_yes;
      default:   next_state = ST_IDLE;
    endcase
    // Menu press advances, or jumps to save from the return mark
    if (in_sess && ev_menu && state != ST_SAVE) begin
      next_state = at_r ? ST_SAVE : succ(state, other_sel);
      next_cur   = 4'h0;
      next_yes   = 1'b1;
    end
    if (state == ST_SAVE && ev_menu) begin
      next_state = ST_IDLE;
      if (!save_yes) next_pend = saved;
    end
    if (in_sess && tdone) begin
      next_state = ST_IDLE;
      next_pend  = saved;
    end
  end

  // Menu registers; settings reload from storage just after reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_LAMP;
      cur       <= 4'h0;
      other_sel <= 1'b0;
      save_yes  <= 1'b1;
      pend      <= `CVC_RST_SET;
      saved     <= `CVC_RST_SET;
      nv_loaded <= 1'b0;
      nv_wr_en  <= 1'b0;
      rf_mute   <= 1'b0;
      tmr       <= 32'h0000_0000;
    end else begin
      state     <= next_state;
      cur       <= next_cur;
      other_sel <= next_other;
      save_yes  <= next_yes;
      nv_loaded <= 1'b1;
      nv_wr_en  <= commit;
      rf_mute   <= (next_state == ST_FREQ);
      if (!nv_loaded) begin
        pend  <= nv_rd_data;
        saved <= nv_rd_data;
      end else begin
        pend <= next_pend;
        if (commit) saved <= pend;
      end
      if (any_ev || next_state != state) tmr <= 32'h0000_0000;
      else if (!tdone) tmr <= tmr + 32'h0000_0001;
    end
  end

  // Applied settings: frequency from saved copy, gain live from pending
  assign nv_wr_data    = saved;
  assign freq_bcd      = saved[`CVC_F_FREQ +: `CVC_FREQ_W];
  assign gain_db       = p_gain;
  assign ref_insert    = saved[`CVC_F_REFINS];
  assign ext_ref_sel   = saved[`CVC_F_EXTREF];
  assign step_sel      = cvc_step_t'(saved[`CVC_F_STEP +: 2]);
  assign line_std      = cvc_line_t'(saved[`CVC_F_LINE +: 2]);
  assign remote_led    = saved[`CVC_F_REMOTE];
  assign alarm_led     = alarm;
  assign disp_state    = state;
  assign disp_cursor   = cur;
  assign disp_settings = pend;
  assign disp_other    = other_sel;
  assign disp_save_yes = save_yes;
  assign disp_version  = FW_VERSION;

  // Serial receiver and transmitter
  logic       rx_valid, tx_ready;
  logic [7:0] rx_data;
  cvc_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .rx_line  (pin_f[0]),
    .rx_valid (rx_valid),
    .rx_data  (rx_data)
  );

  // Status reply, always built with address; skipped when not multidrop
  wire [`CVC_GAIN_W-1:0] s_gain = saved[`CVC_F_GAIN +: `CVC_GAIN_W];
  wire [`CVC_GAIN_W-1:0] g_ten  = s_gain / 6'h0a;
  wire [`CVC_GAIN_W-1:0] g_one  = s_gain % 6'h0a;
  wire [`CVC_ADDR_W-1:0] s_addr = saved[`CVC_F_ADDR +: `CVC_ADDR_W];
  wire                   is485  = (saved[`CVC_F_LINE +: 2] == LINE_485);
  logic [7:0] rep [0:17];
  assign rep[0]  = `CVC_CH_OPEN;
  assign rep[1]  = {`CVC_ASCII_DIG, s_addr[7:4]};
  assign rep[2]  = {`CVC_ASCII_DIG, s_addr[3:0]};
  assign rep[3]  = `CVC_CH_STAT;
  assign rep[4]  = `CVC_CH_ONE;
  for (genvar j = 0; j < FD; j++) begin : g_rfrq
    assign rep[5+j] = {`CVC_ASCII_DIG, freq_bcd[(FD-1-j)*4 +: 4]};
  end
  assign rep[12] = {`CVC_ASCII_DIG, g_ten[3:0]};
  assign rep[13] = {`CVC_ASCII_DIG, g_one[3:0]};
  assign rep[14] = ref_insert ? `CVC_CH_ONE : `CVC_CH_ZERO;
  assign rep[15] = ext_ref_sel ? `CVC_CH_ZERO : `CVC_CH_ONE;
  assign rep[16] = alarm ? `CVC_CH_ONE : `CVC_CH_ZERO;
  assign rep[17] = `CVC_CH_CLOSE;

  // Frame collector between braces; overlong frames are dropped
  logic [7:0] rx_buf [0:`CVC_RX_DEPTH-1];
  logic [3:0] rx_len;
  logic       in_frame, frame_done;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_frame   <= 1'b0;
      frame_done <= 1'b0;
      rx_len     <= 4'h0;
    end else begin
      frame_done <= 1'b0;
      if (rx_valid) begin
        if (rx_data == `CVC_CH_OPEN) begin
          in_frame <= 1'b1;
          rx_len   <= 4'h0;
        end else if (in_frame && rx_data == `CVC_CH_CLOSE) begin
          in_frame   <= 1'b0;
          frame_done <= 1'b1;
        end else if (in_frame) begin
          if (rx_len == 4'(`CVC_RX_DEPTH)) in_frame <= 1'b0;
          else rx_len <= rx_len + 4'h1;
        end
      end
    end
  end

  // Buffer memory, written only inside a frame
  always_ff @(posedge core_clk) begin
    if (rx_valid && in_frame && rx_data != `CVC_CH_CLOSE && rx_len < 4'(`CVC_RX_DEPTH))
      rx_buf[rx_len] <= rx_data;
  end

  // Frame decode; the address field is expected only on the multidrop line
  wire [7:0] c0      = is485 ? rx_buf[2] : rx_buf[0];
  wire [7:0] c1      = is485 ? rx_buf[3] : rx_buf[1];
  wire [3:0] need    = is485 ? 4'h4 : 4'h2;
  wire       addr_ok = ~is485 || (rx_buf[0] == rep[1] && rx_buf[1] == rep[2]);
  wire       go_stat = frame_done && addr_ok && rx_len == need &&
                       c0 == `CVC_CH_STAT && c1 == `CVC_CH_ONE;
  wire       go_ack  = frame_done && addr_ok && rx_len >= need && c0 == `CVC_CH_CMD;

  // Reply sequencer; a frame arriving mid-reply is ignored
  logic       tx_busy, tx_stat;
  logic [4:0] tx_idx;
  wire  [4:0] tx_last = ~tx_stat ? 5'h00 : is485 ? 5'h11 : 5'h0f;
  wire  [4:0] eff_idx = (~is485 && tx_idx != 5'h00) ? tx_idx + 5'h02 : tx_idx;
  wire  [7:0] tx_char = tx_stat ? rep[eff_idx] : `CVC_CH_ACK;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy <= 1'b0;
      tx_stat <= 1'b0;
      tx_idx  <= 5'h00;
    end else if (!tx_busy) begin
      tx_busy <= go_stat | go_ack;
      tx_stat <= go_stat;
      tx_idx  <= 5'h00;
    end else if (tx_ready) begin
      if (tx_idx == tx_last) tx_busy <= 1'b0;
      else tx_idx <= tx_idx + 5'h01;
    end
  end

  cvc_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tx_data  (tx_char),
    .tx_valid (tx_busy),
    .tx_ready (tx_ready),
    .tx_line  (tx_pin)
  );
endmodule

// ---- test/cvc_ctrl_asserts.sv ----
`timescale 1ns/1ps
`include "cvc_regs.svh"
module cvc_ctrl_asserts (
  input wire logic                   core_clk,
  input wire logic                   rst_n,
  input wire logic                   tx_pin,
  input wire logic                   pll_unlock,
  input wire logic [`CVC_SET_W-1:0]  nv_wr_data,
  input wire logic                   nv_wr_en,
  input wire logic [`CVC_FREQ_W-1:0] freq_bcd,
  input wire logic [`CVC_GAIN_W-1:0] gain_db,
  input wire logic                   rf_mute,
  input wire logic                   ref_insert,
  input wire logic                   alarm_led,
  input wire logic                   remote_led,
  input wire cvc_pkg::cvc_state_t    disp_state
);
  import cvc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Menu and save sequencing
  AST_ONE_STATE: assert property ($onehot(disp_state))
    else $error("menu state not one-hot");
  AST_MUTE_FREQ: assert property (rf_mute |-> disp_state == ST_FREQ || $past(disp_state) == ST_FREQ)
    else $error("mute outside frequency item");
  AST_WR_PULSE: assert property (nv_wr_en |=> !nv_wr_en)
    else $error("store strobe longer than one cycle");
  AST_WR_AFTER_SAVE: assert property (nv_wr_en |-> $past(disp_state) == ST_SAVE
    || $past(disp_state, 2) == ST_SAVE)
    else $error("store without save prompt");
  AST_FREQ_ON_SAVE: assert property ($changed(freq_bcd) && $past(disp_state) != ST_LAMP
    |-> $past(disp_state) == ST_SAVE || $past(disp_state, 2) == ST_SAVE)
    else $error("frequency applied without save");
  // Applied frequency, remote and insertion fields must mirror the stored word, so power loss loses nothing
  AST_SAVED_MIRROR: assert property (freq_bcd == nv_wr_data[27:0]
    && remote_led == nv_wr_data[`CVC_F_REMOTE] && ref_insert == nv_wr_data[`CVC_F_REFINS])
    else $error("applied fields differ from stored word");
  AST_GAIN_RANGE: assert property (gain_db <= `CVC_GAIN_MAX)
    else $error("gain above range");
  // Alarm follows lock loss within the filter delay
  AST_ALARM_SET: assert property (pll_unlock [*8] |-> ##[0:40] alarm_led)
    else $error("alarm missing on lock loss");
  AST_ALARM_CLR: assert property (!pll_unlock [*8] |-> ##[0:40] !alarm_led)
    else $error("alarm stuck while locked");
  AST_TX_START: assert property ($fell(tx_pin) |=> !tx_pin [*8])
    else $error("start bit too short");
endmodule
bind cvc_ctrl cvc_ctrl_asserts u_cvc_ctrl_asserts (.core_clk(core_clk), .rst_n(rst_n),
  .tx_pin(tx_pin), .pll_unlock(pll_unlock), .nv_wr_data(nv_wr_data), .nv_wr_en(nv_wr_en),
  .freq_bcd(freq_bcd), .gain_db(gain_db), .rf_mute(rf_mute), .ref_insert(ref_insert),
  .alarm_led(alarm_led), .remote_led(remote_led), .disp_state(disp_state));

// ---- test/cvc_host.sv ----
`timescale 1ns/1ps
module cvc_host #(
  parameter int BIT_CYC = 16
) (
  input wire logic core_clk,
  input wire logic tx_pin,
  output logic     rx_pin
);
  logic [7:0] rxq[$];
  logic [7:0] b;
  initial rx_pin = 1'b1;
  // Start, eight data bits LSB first, one stop; line idles high
  task automatic send_byte(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_pin <= f[i];
      repeat (BIT_CYC) @(posedge core_clk);
    end
  endtask
  // Whole frame sent character by character; any address must already be in the string
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) send_byte(s[i]);
  endtask
  // Sample mid-bit; a bad stop bit drops the character
  always begin
    @(negedge tx_pin);
    repeat (BIT_CYC / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge core_clk);
      b[i] = tx_pin;
    end
    repeat (BIT_CYC) @(posedge core_clk);
    if (tx_pin) rxq.push_back(b);
  end
endmodule

// ---- test/cvc_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`include "cvc_regs.svh"
module cvc_ctrl_tb_top;
  import cvc_pkg::*;
  localparam logic [48:0] NV0 = {8'h00, 6'h00, 1'b1, 6'h14, 28'h215_0000};
  logic        core_clk, rst_n, tx_pin, rx_pin, pll_unlock, nv_wr_en, rf_mute;
  logic        ref_insert, alarm_led, remote_led;
  logic [4:0]  sw;
  logic [5:0]  gain_lo, gain_hi, gain_db;
  logic [48:0] nv_rd, nv_wr, disp_set;
  logic [27:0] freq_bcd, f1;
  cvc_state_t  disp_state;
  logic        ext_ref;
  cvc_step_t   step_s;
  cvc_line_t   line_s;
  int          miscompares, comparisons, wr_cnt;
  cvc_ctrl #(.BIT_CYC(16), .TIMEOUT_CYC(32'd2000), .LAMP_CYC(32'd50), .VER_CYC(32'd50))
  u_cvc_ctrl (
    .core_clk(core_clk), .rst_n(rst_n), .rx_pin(rx_pin), .tx_pin(tx_pin), .sw_menu(sw[0]),
    .sw_left(sw[1]), .sw_right(sw[2]), .sw_up(sw[3]), .sw_down(sw[4]), .pll_unlock(pll_unlock),
    .gain_lo_lim(gain_lo), .gain_hi_lim(gain_hi), .nv_rd_data(nv_rd), .nv_wr_data(nv_wr),
    .nv_wr_en(nv_wr_en), .freq_bcd(freq_bcd), .gain_db(gain_db), .rf_mute(rf_mute),
    .ref_insert(ref_insert), .ext_ref_sel(ext_ref), .step_sel(step_s), .line_std(line_s),
    .alarm_led(alarm_led),
    .remote_led(remote_led), .disp_state(disp_state), .disp_cursor(), .disp_settings(disp_set),
    .disp_other(), .disp_save_yes(), .disp_version());
  cvc_host #(.BIT_CYC(16)) u_cvc_host (.core_clk(core_clk), .tx_pin(tx_pin), .rx_pin(rx_pin));
  // 200 MHz clock and store-strobe count
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (nv_wr_en === 1'b1) wr_cnt <= wr_cnt + 1;
  task chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Held long enough to clear the switch filter
  task press(input int i);
    @(posedge core_clk) sw[i] <= 1'b1;
    repeat (10) @(posedge core_clk);
    sw[i] <= 1'b0;
    repeat (10) @(posedge core_clk);
  endtask
  task query(input string q, input string r);
    int n;
    repeat (40) @(posedge core_clk);
    u_cvc_host.rxq.delete();
    u_cvc_host.send_str(q);
    n = 0;
    while (u_cvc_host.rxq.size() < r.len() && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    chk(u_cvc_host.rxq.size(), r.len());
    for (int i = 0; i < r.len() && i < u_cvc_host.rxq.size(); i++) chk(u_cvc_host.rxq[i], r[i]);
  endtask
  task tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0; sw = 5'h00; pll_unlock = 1'b0; gain_lo = 6'h00; gain_hi = 6'h23;
    nv_rd = NV0; miscompares = 0; comparisons = 0; wr_cnt = 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (25) @(posedge core_clk);
    chk(disp_state, ST_LAMP);
    chk({freq_bcd, gain_db, ref_insert}, {28'h215_0000, 6'h14, 1'b1});
    repeat (50) @(posedge core_clk);
    chk(disp_state, ST_VER);
    repeat (50) @(posedge core_clk);
    chk(disp_state, ST_IDLE);
    pll_unlock <= 1'b1;
    query("{S1}", "{S1215000020111}");
    chk(alarm_led, 1'b1);
    pll_unlock <= 1'b0;
    query("{C420}", ">");
    press(0);
    chk({disp_state, rf_mute}, {ST_FREQ, 1'b1});
    press(3);
    f1 = disp_set[27:0];
    chk(f1 == 28'h315_0000 || f1 == 28'h215_0001, 1'b1);
    chk(freq_bcd, 28'h215_0000);
    press(0);
    press(3);
    chk({disp_state, gain_db}, {ST_GAIN, 6'h1e});
    press(3);
    chk(gain_db, 6'h1e);
    press(2);
    press(4);
    chk(gain_db, 6'h1d);
    press(0);
    press(0);
    chk(disp_state, ST_SAVE);
    press(0);
    chk({disp_state, freq_bcd, nv_wr[33:28]}, {ST_IDLE, f1, 6'h1d});
    chk(wr_cnt, 1);
    press(0);
    press(3);
    repeat (2100) @(posedge core_clk);
    chk({disp_state, rf_mute, freq_bcd}, {ST_IDLE, 1'b0, f1});
    chk(disp_set, nv_wr);
    for (int k = 0; k < 2; k++) begin
      repeat (3) press(0);
      press(3);
      press(0);
      chk(disp_state, ST_REMOTE);
      press(3);
      repeat (6) press(0);
      chk(disp_state, ST_SAVE);
      if (k == 0) press(3);
      press(0);
      chk({disp_state, remote_led, disp_set}, {ST_IDLE, k[0], nv_wr});
      chk(wr_cnt, k + 1);
    end
    press(0);
    chk({disp_state, remote_led}, {ST_FREQ, 1'b1});
    chk({ext_ref, step_s, line_s}, 5'h00);
    tally_and_finish();
  end
  // Hang guard
  initial begin
    repeat (40000) @(posedge core_clk);
    miscompares++;
    tally_and_finish();
  end
endmodule
